// ==== design/udi_idle_timer.sv ====
/*
  Bus-idle detector: counts consecutive cycles of a synchronised idle J level
  and pulses once when the count reaches the configured length.
  Assumes the J level input is already in the hclk domain.
*/
`timescale 1ns/100ps
module udi_idle_timer #(
  parameter int unsigned IDLE_CYCLES = udi_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Line state
  input  wire logic line_j,
  output logic      idle_pulse
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        fired;
  } udi_idle_state_t;

  udi_idle_state_t s_q;
  udi_idle_state_t s_d;

  always_comb begin
    s_d = s_q;
    idle_pulse = 1'b0;
    if (!line_j) begin
      s_d.cnt = 32'h0000_0000;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt == IDLE_CYCLES - 1) begin
        idle_pulse = 1'b1;
        s_d.fired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== design/udi_pkg.sv ====
/*
  Package for the device interrupt and endpoint configuration block:
  register offsets, field positions, reset values and the AHB-Lite carrier.
  Assumes a single 40 MHz clock domain and 32-bit AHB-Lite register access.
*/
package udi_pkg;

  localparam int unsigned NUM_EP      = 16;
  localparam int unsigned CLK_KHZ     = 40000;
  localparam int unsigned IDLE_MS     = 3;
  // Idle J duration in cycles before the bus-idle flag is raised
  localparam int unsigned IDLE_CYCLES = IDLE_MS * CLK_KHZ;

  localparam logic [11:0] OFS_EN_CLR   = 12'h014;
  localparam logic [11:0] OFS_EN_SET   = 12'h018;
  localparam logic [11:0] OFS_FLAGS    = 12'h01c;
  localparam logic [11:0] OFS_SUMMARY  = 12'h020;
  localparam logic [11:0] OFS_FRAME_NUM = 12'h024;
  localparam logic [11:0] OFS_EPCFG    = 12'h100;
  localparam logic [11:0] EPCFG_STRIDE = 12'h020;

  localparam logic [15:0] IRQ_IMPL_MASK = 16'h03fd;
  localparam logic [15:0] IRQ_RESET     = 16'h0000;
  localparam logic [7:0]  EPCFG_MASK    = 8'h77;
  localparam logic [7:0]  EPCFG_RESET   = 8'h00;

  localparam int unsigned BIT_LPM_SUSP  = 9;
  localparam int unsigned BIT_LPM_NYET  = 8;
  localparam int unsigned BIT_RAM_ERR   = 7;
  localparam int unsigned BIT_UP_RSM    = 6;
  localparam int unsigned BIT_RSM_END   = 5;
  localparam int unsigned BIT_WAKE      = 4;
  localparam int unsigned BIT_RST_END   = 3;
  localparam int unsigned BIT_SOF       = 2;
  localparam int unsigned BIT_IDLE      = 0;

  localparam int unsigned TYPE1_LSB = 4;
  localparam int unsigned TYPE0_LSB = 0;

  localparam logic [2:0] EPT_DISABLED = 3'h0;
  localparam logic [2:0] EPT_CONTROL  = 3'h1;
  localparam logic [2:0] EPT_ISO      = 3'h2;
  localparam logic [2:0] EPT_BULK     = 3'h3;
  localparam logic [2:0] EPT_INTR     = 3'h4;
  localparam logic [2:0] EPT_DUAL     = 3'h5;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } udi_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } udi_ahb_rsp_t;

  // Link-side event strobes, one cycle each, and the frame number taken with sof
  typedef struct packed {
    logic        lpm_ack_suspend;
    logic        lpm_nyet;
    logic        ram_error;
    logic        upstream_resume;
    logic        resume_end;
    logic        line_wake;
    logic        bus_reset_end;
    logic        sof;
    logic [10:0] sof_frame_number;
  } udi_evt_t;

endpackage

// ==== design/udi_top.sv ====
/*
  Device interrupt enables and flags, endpoint interrupt summary and
  endpoint type configuration of a full-speed USB device, on AHB-Lite.
  Assumes link events arrive as one-cycle strobes on hclk; the bus line
  J level comes from a pin and is synchronised here.
*/
`timescale 1ns/100ps
module udi_top #(
  parameter int unsigned IDLE_CYCLES = udi_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire udi_pkg::udi_ahb_req_t ahb_req,
  output udi_pkg::udi_ahb_rsp_t      ahb_rsp,
  // Link events
  input  wire udi_pkg::udi_evt_t     evt,
  input  wire logic                 bus_reset_pulse,
  input  wire logic                 line_j_pin,
  input  wire logic [15:0]          endpoint_pending_bits,
  // Configuration and interrupt out
  output logic [127:0]              endpoint_type_flat,
  output logic                      irq
);

  localparam int unsigned N = udi_pkg::NUM_EP;

  typedef struct packed {
    logic [15:0]   enables;
    logic [15:0]   flags;
    logic [10:0]   frame_number;
    logic [N-1:0][7:0] epcfg;
    logic [11:0]   addr;
    logic          wr;
    logic [31:0]   rdata;
    logic [1:0]    line_sync;
  } udi_top_state_t;

  udi_top_state_t    s_q;
  udi_top_state_t    s_d;
  logic              idle_pulse;
  logic [15:0]       set_ev;
  logic [15:0]       wmask;
  logic              take;
  logic              wr_en_set;
  logic              wr_en_clr;
  logic              wr_flags;
  logic [15:0]       enables_nx;
  logic [15:0]       flags_nx;
  logic [10:0]       frame_nx;
  logic [N-1:0][7:0] epcfg_nx;
  logic [N:0][7:0]   rd_chain;
  logic [31:0]       rd_next;

  udi_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .line_j     (s_q.line_sync[1]),
    .idle_pulse (idle_pulse)
  );

  always_comb begin
    set_ev = 16'h0000;
    set_ev[udi_pkg::BIT_LPM_SUSP] = evt.lpm_ack_suspend;
    set_ev[udi_pkg::BIT_LPM_NYET] = evt.lpm_nyet;
    set_ev[udi_pkg::BIT_RAM_ERR] = evt.ram_error;
    set_ev[udi_pkg::BIT_UP_RSM] = evt.upstream_resume;
    set_ev[udi_pkg::BIT_RSM_END] = evt.resume_end;
    set_ev[udi_pkg::BIT_WAKE] = evt.line_wake;
    set_ev[udi_pkg::BIT_RST_END] = evt.bus_reset_end;
    set_ev[udi_pkg::BIT_SOF] = evt.sof;
    set_ev[udi_pkg::BIT_IDLE] = idle_pulse;
  end

  assign take      = ahb_req.hsel && ahb_req.hready
                     && (ahb_req.htrans == udi_pkg::HTRANS_NONSEQ);
  assign wmask     = ahb_req.hwdata[15:0] & udi_pkg::IRQ_IMPL_MASK;
  assign wr_en_set = s_q.wr && (s_q.addr == udi_pkg::OFS_EN_SET);
  assign wr_en_clr = s_q.wr && (s_q.addr == udi_pkg::OFS_EN_CLR);
  assign wr_flags  = s_q.wr && (s_q.addr == udi_pkg::OFS_FLAGS);

  // Set and clear views act on one shared enable state
  always_comb begin
    enables_nx = s_q.enables;
    if (wr_en_set) begin
      enables_nx = s_q.enables | wmask;
    end
    if (wr_en_clr) begin
      enables_nx = s_q.enables & ~wmask;
    end
  end

  for (genvar b = 0; b < 16; b++) begin : g_flag
    always_comb begin
      flags_nx[b] = s_q.flags[b];
      if (wr_flags && wmask[b]) begin
        flags_nx[b] = 1'b0;
      end
      // Hardware set wins over a same-cycle clear
      if (set_ev[b]) begin
        flags_nx[b] = 1'b1;
      end
      if (!udi_pkg::IRQ_IMPL_MASK[b]) begin
        flags_nx[b] = 1'b0;
      end
    end
  end

  always_comb begin
    frame_nx = s_q.frame_number;
    if (evt.sof) begin
      frame_nx = evt.sof_frame_number;
    end
  end

  assign rd_chain[0] = 8'h00;

  for (genvar e = 0; e < N; e++) begin : g_ep
    localparam logic [11:0] EP_OFS = 12'(udi_pkg::OFS_EPCFG + e * udi_pkg::EPCFG_STRIDE);
    logic ep_wr;
    logic ep_rd;
    assign ep_wr = s_q.wr && (s_q.addr == EP_OFS);
    assign ep_rd = (ahb_req.haddr[11:0] == EP_OFS);
    always_comb begin
      epcfg_nx[e] = s_q.epcfg[e];
      if (ep_wr) begin
        epcfg_nx[e] = ahb_req.hwdata[7:0] & udi_pkg::EPCFG_MASK;
      end
      // Bus reset beats a same-cycle write; endpoint 0 keeps its types
      if (bus_reset_pulse && (e != 0)) begin
        epcfg_nx[e] = udi_pkg::EPCFG_RESET;
      end
    end
    assign rd_chain[e+1] = rd_chain[e] | (ep_rd ? epcfg_nx[e] : 8'h00);
    assign endpoint_type_flat[e*8 +: 8] = s_q.epcfg[e];
  end

  // Read data sees a write landing in the same cycle
  always_comb begin
    rd_next = 32'h0000_0000;
    case (ahb_req.haddr[11:0])
      udi_pkg::OFS_EN_CLR, udi_pkg::OFS_EN_SET: begin
        rd_next = {16'h0000, enables_nx};
      end
      udi_pkg::OFS_FLAGS: begin
        rd_next = {16'h0000, flags_nx};
      end
      udi_pkg::OFS_SUMMARY: begin
        rd_next = {16'h0000, endpoint_pending_bits};
      end
      udi_pkg::OFS_FRAME_NUM: begin
        rd_next = {21'h00_0000, frame_nx};
      end
      default: begin
        rd_next = {24'h00_0000, rd_chain[N]};
      end
    endcase
  end

  always_comb begin
    s_d              = s_q;
    s_d.line_sync    = {s_q.line_sync[0], line_j_pin};
    s_d.enables      = enables_nx;
    s_d.flags        = flags_nx;
    s_d.frame_number = frame_nx;
    s_d.epcfg        = epcfg_nx;
    s_d.wr           = 1'b0;
    if (take) begin
      s_d.addr = ahb_req.haddr[11:0];
      s_d.wr   = ahb_req.hwrite;
      if (!ahb_req.hwrite) begin
        s_d.rdata = rd_next;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq = (|(s_q.flags & s_q.enables)) || (|endpoint_pending_bits);
  assign ahb_rsp.hrdata = s_q.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;

endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench of udi_top with the host model on the link side.
   Assumes the bench is the only bus master; hreadyout is hready. */
`timescale 1ns/100ps
module testbench;
  localparam int unsigned IDLE = 20;
  logic hclk, hresetn, irq, go, busrst, idle, bus_reset_pulse, line_j_pin;
  logic [3:0] bitn;
  logic [10:0] fn;
  logic [15:0] pend, en, fl;
  logic [31:0] r, d;
  logic [127:0] flat;
  udi_pkg::udi_ahb_req_t req, ahb_req;
  udi_pkg::udi_ahb_rsp_t ahb_rsp;
  udi_pkg::udi_evt_t evt;
  int seed = 19, bad_count = 0, tests_run = 0;
  int evb[8] = '{9, 8, 7, 6, 5, 4, 3, 2};
  logic [11:0] ofs[7] = '{12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h100, 12'h0fc};
  assign ahb_req = {req[71:33], ahb_rsp.hreadyout, req[31:0]};
  always #12.5 hclk = ~hclk;
  udi_top #(.IDLE_CYCLES(IDLE)) udi_top_i (.hclk, .hresetn, .ahb_req, .ahb_rsp, .evt,
    .bus_reset_pulse, .line_j_pin, .endpoint_pending_bits(pend), .endpoint_type_flat(flat), .irq);
  udi_host_model udi_host_model_i (.hclk, .go, .bitn, .fn, .busrst, .idle, .evt,
    .bus_reset_pulse, .line_j_pin);
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    req.htrans <= 2'b10;
    req.haddr <= {20'h0_0000, a};
    req.hwrite <= w;
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    r = ahb_rsp.hrdata;
  endtask
  task automatic fire(input int b);
    @(posedge hclk);
    go <= 1'b1;
    bitn <= 4'(b);
    fn <= 11'($random(seed));
    @(posedge hclk);
    go <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  function automatic logic [31:0] irq_exp();
    return 32'(((fl & en) != 16'h0000) || (pend != 16'h0000));
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    bad_count++;
    final_report();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    req = '0;
    req.hsel = 1'b1;
    req.hsize = 3'h2;
    {go, busrst, idle, bitn, fn, pend, en, fl} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ofs[i]) begin
      xfer(1'b0, ofs[i], 32'h0000_0000);
      chk("reset", r, 32'h0000_0000);
    end
    $display("reset done");
    repeat (3) begin
      d = $random(seed) & 32'h0000_03fd;
      xfer(1'b1, 12'h018, d);
      en |= d[15:0] & 16'h03fd;
      d = $random(seed) & 32'h0000_03fd;
      xfer(1'b1, 12'h014, d);
      en &= ~d[15:0];
      xfer(1'b0, 12'h018, 32'h0000_0000);
      chk("en set", r, {16'h0000, en});
      xfer(1'b0, 12'h014, 32'h0000_0000);
      chk("en clr", r, {16'h0000, en});
    end
    $display("enable done");
    foreach (evb[i]) begin
      fire(evb[i]);
      fl[evb[i]] = 1'b1;
      chk("irq", 32'(irq), irq_exp());
      xfer(1'b0, 12'h01c, 32'h0000_0000);
      chk("flags", r, {16'h0000, fl});
    end
    xfer(1'b0, 12'h024, 32'h0000_0000);
    chk("frame", r, {21'h0, fn});
    d = $random(seed) & 32'h0000_03fd;
    xfer(1'b1, 12'h01c, d);
    fl &= ~d[15:0];
    xfer(1'b0, 12'h01c, 32'h0000_0000);
    chk("w1c", r, {16'h0000, fl});
    xfer(1'b1, 12'h01c, 32'h0000_03fd);
    fl = 16'h0000;
    $display("events done");
    idle <= 1'b1;
    repeat (IDLE) @(posedge hclk);
    xfer(1'b0, 12'h01c, 32'h0000_0000);
    chk("idle early", r, 32'h0000_0000);
    xfer(1'b0, 12'h01c, 32'h0000_0000);
    chk("idle", r, 32'h0000_0001);
    idle <= 1'b0;
    xfer(1'b1, 12'h01c, 32'h0000_0001);
    $display("idle done");
    for (int i = 0; i < 3; i++) begin
      pend <= (i == 2) ? 16'h0000 : 16'($random(seed));
      xfer(1'b0, 12'h020, 32'h0000_0000);
      chk("summary", r, {16'h0000, pend});
      chk("irq", 32'(irq), irq_exp());
    end
    $display("summary done");
    for (int n = 0; n < 16; n++) begin
      d = {24'h00_0000, 1'b0, 3'(n), 1'b0, 3'(n + 3)};
      xfer(1'b1, 12'h100 + 12'(n * 32), d);
      xfer(1'b0, 12'h100 + 12'(n * 32), 32'h0000_0000);
      chk("ep type", r, d & 32'h0000_0077);
    end
    busrst <= 1'b1;
    @(posedge hclk);
    busrst <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("ep0 kept", 32'(flat[7:0]), 32'h0000_0003);
    chk("eps cleared", 32'(|flat[127:8]), 32'h0000_0000);
    $display("config done");
    final_report();
  end
endmodule

// ==== verification/udi_host_model.sv ====
/* Host side of the link: turns bench commands into device event strobes.
   Assumes commands change just after a rising hclk edge. */
`timescale 1ns/100ps
module udi_host_model (
  // Clock
  input  wire logic         hclk,
  // Bench commands
  input  wire logic         go,
  input  wire logic [3:0]   bitn,
  input  wire logic [10:0]  fn,
  input  wire logic         busrst,
  input  wire logic         idle,
  // Device side
  output udi_pkg::udi_evt_t evt,
  output logic              bus_reset_pulse,
  output logic              line_j_pin
);
  // One-cycle strobes; frame number travels with every strobe
  always @(posedge hclk) begin
    evt <= {go ? 8'h01 << (bitn - 4'h2) : 8'h00, fn};
    bus_reset_pulse <= busrst;
    line_j_pin <= idle;
  end
endmodule

// ==== verification/udi_props.sv ====
/* Assertions on the ports of udi_top.
   Assumes one hclk domain and single word bus transfers. */
`timescale 1ns/100ps
module udi_props (
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Register bus
  input wire udi_pkg::udi_ahb_req_t ahb_req,
  input wire udi_pkg::udi_ahb_rsp_t ahb_rsp,
  // Link and outputs
  input wire logic                  bus_reset_pulse,
  input wire logic [15:0]           endpoint_pending_bits,
  input wire logic [127:0]          endpoint_type_flat,
  input wire logic                  irq
);
  logic        rd_q;
  logic [11:0] ad_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ad_q <= 12'h000;
    end else begin
      rd_q <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans == 2'b10 && !ahb_req.hwrite;
      ad_q <= ahb_req.haddr[11:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pending_irq: assert property (|endpoint_pending_bits |-> irq)
    else $error("irq low while pending");
  a_resp_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bad bus response");
  a_cfg_reserved: assert property ((endpoint_type_flat & {16{8'h88}}) == 128'h0)
    else $error("config reserved bit set");
  a_reset_clears: assert property (bus_reset_pulse |-> ##[1:2] endpoint_type_flat[127:8] == 120'h0)
    else $error("types not cleared");
  a_ep0_kept: assert property (bus_reset_pulse |=> $stable(endpoint_type_flat[7:0]) [*2])
    else $error("endpoint 0 type changed");
  a_flag_reserved: assert property (rd_q && ad_q inside {12'h014, 12'h018, 12'h01c} |->
    (ahb_rsp.hrdata & 32'hffff_fc02) == 32'h0000_0000) else $error("reserved bit read one");
  a_summary_live: assert property (rd_q && ad_q == 12'h020 |->
    ahb_rsp.hrdata == {16'h0000, $past(endpoint_pending_bits)}) else $error("summary wrong");
  a_unmapped_zero: assert property (rd_q && ad_q == 12'h0fc |-> ahb_rsp.hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind udi_top udi_props udi_props_i (.hclk, .hresetn, .ahb_req, .ahb_rsp, .bus_reset_pulse,
  .endpoint_pending_bits, .endpoint_type_flat, .irq);
